/* File: rtl/mpd_defs.vh */
// Purpose: constants for the memory partition decoder
// Assumes: 32-bit byte addresses, register port word offsets
// Notes: partition base registers move in 2 KB steps
`ifndef MPD_DEFS_VH
`define MPD_DEFS_VH
// Register offsets
`define MPD_REG_USER_FLASH_BASE 8'h00
`define MPD_REG_KRAM_PROG_BASE 8'h04
`define MPD_REG_USER_RAM_DATA_BASE 8'h08
`define MPD_REG_USER_RAM_PROG_BASE 8'h0c
`define MPD_REG_DATA_RAM_SIZE 8'h10
`define MPD_REG_PROGRAM_FLASH_SIZE 8'h14
`define MPD_REG_BOOT_FLASH_SIZE 8'h18
`define MPD_REG_STATUS 8'h1c
// Static sizes
`define MPD_BOOT_FLASH_SIZE 32'h00003000
`define MPD_DATA_RAM_SIZE 32'h00008000
`define MPD_PROGRAM_FLASH_SIZE 32'h00080000
// Base register writable fields
`define MPD_FLASH_BASE_MASK 32'h000ff800
`define MPD_RAM_BASE_MASK 32'h0000f800
// Address map
`define MPD_KERNEL_START 32'h80000000
`define MPD_RESET_VECTOR 32'hbfc00000
`define MPD_PHYS_FLASH 32'h1d000000
`define MPD_PHYS_USER_FLASH 32'hbd000000
`define MPD_PHYS_RAM 32'h00000000
`define MPD_PHYS_USER_RAM 32'hbf000000
`define MPD_PHYS_BOOT 32'h1fc00000
`define MPD_PHYS_PERIPH 32'h1f800000
`define MPD_PERIPH_SIZE 32'h00100000
`define MPD_CACHED_KERNEL_SEGMENT_FLASH 32'h9d000000
`define MPD_UNCACHED_KERNEL_SEGMENT_FLASH 32'hbd000000
`define MPD_USEG_FLASH 32'h7d000000
`define MPD_USEG_RAM 32'h7f000000
`define MPD_SEG_MASK 32'h1fffffff
// Target codes
`define MPD_TGT_NONE 3'h0
`define MPD_TGT_RAM 3'h1
`define MPD_TGT_FLASH 3'h2
`define MPD_TGT_BOOT 3'h3
`define MPD_TGT_PERIPH 3'h4
`endif

/* File: rtl/mpd_decode.v */
// Purpose: combinational decode of one virtual address
// Assumes: base registers already masked to 2 KB steps
// Notes: one instance per requester
`timescale 1ns/1ps
`include "mpd_defs.vh"
module mpd_decode (
  // Request
  input wire [31:0] vaddr,
  input wire kernel_mode,
  input wire is_fetch,
  // Partition bases
  input wire [31:0] user_flash_base,
  input wire [31:0] kernel_ram_program_base,
  input wire [31:0] user_ram_data_base,
  input wire [31:0] user_ram_program_base,
  // Result
  output reg [31:0] paddr,
  output reg [2:0] target,
  output reg cacheable,
  output reg unmapped
);
  reg [31:0] off;
  reg [31:0] kram_end;
  reg ok;
  always @* begin
    paddr = 32'h0;
    target = `MPD_TGT_NONE;
    cacheable = 1'b0;
    ok = 1'b0;
    off = 32'h0;
    // Kernel RAM stops at the user RAM data base if set, else at the user RAM program base if set, else at the data RAM size
    kram_end = (user_ram_data_base != 32'h0) ? user_ram_data_base :
               (user_ram_program_base != 32'h0) ? user_ram_program_base :
               `MPD_DATA_RAM_SIZE;
    if (vaddr < `MPD_KERNEL_START) begin
      // User segment, reachable in either mode
      if (vaddr >= `MPD_USEG_FLASH && vaddr < `MPD_USEG_FLASH + `MPD_PROGRAM_FLASH_SIZE) begin
        off = vaddr - `MPD_USEG_FLASH;
        ok = (user_flash_base != 32'h0) && (off >= user_flash_base) && !is_fetch |
          ((user_flash_base != 32'h0) && (off >= user_flash_base));
        paddr = `MPD_PHYS_USER_FLASH + off;
        target = `MPD_TGT_FLASH;
      end else if (vaddr >= `MPD_USEG_RAM && vaddr < `MPD_USEG_RAM + `MPD_DATA_RAM_SIZE) begin
        off = vaddr - `MPD_USEG_RAM;
        paddr = `MPD_PHYS_USER_RAM + off;
        target = `MPD_TGT_RAM;
        if (user_ram_program_base != 32'h0 && off >= user_ram_program_base)
          ok = 1'b1;
        else
          ok = (user_ram_data_base != 32'h0) && (off >= user_ram_data_base) && !is_fetch;
      end
    end else if (kernel_mode) begin
      cacheable = (vaddr[31:29] == 3'h4);
      off = vaddr & `MPD_SEG_MASK;
      paddr = off;
      if (vaddr[31:30] != 2'h2) begin
        ok = 1'b0;
      end else if (off < `MPD_DATA_RAM_SIZE) begin
        target = `MPD_TGT_RAM;
        // Kernel data from 0, kernel program above its base; fetch only in program part
        if (off < kram_end)
          ok = is_fetch ? (kernel_ram_program_base != 32'h0 &&
                          off >= kernel_ram_program_base) : 1'b1;
      end else if (off >= `MPD_PHYS_FLASH && off < `MPD_PHYS_FLASH + `MPD_PROGRAM_FLASH_SIZE) begin
        target = `MPD_TGT_FLASH;
        ok = (user_flash_base == 32'h0) ||
          (off - `MPD_PHYS_FLASH < user_flash_base);
      end else if (off >= `MPD_PHYS_BOOT && off < `MPD_PHYS_BOOT + `MPD_BOOT_FLASH_SIZE) begin
        target = `MPD_TGT_BOOT;
        ok = 1'b1;
      end else if (!cacheable && off >= `MPD_PHYS_PERIPH &&
                   off < `MPD_PHYS_PERIPH + `MPD_PERIPH_SIZE) begin
        target = `MPD_TGT_PERIPH;
        ok = !is_fetch;
      end
    end
    unmapped = !ok;
    if (!ok)
      target = `MPD_TGT_NONE;
  end
endmodule // mpd_decode

/* File: rtl/mpd_top.v */
// Purpose: user/kernel partition decoder for instruction and data requesters
// Assumes: register port with one-cycle read latency; inputs synchronous
// Notes: decode outputs registered, one cycle after the request
`timescale 1ns/1ps
`include "mpd_defs.vh"
module mpd_top (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Instruction requester
  input wire ifetch_req,
  input wire [31:0] ifetch_vaddr,
  input wire ifetch_kernel_mode,
  output reg [31:0] ifetch_paddr,
  output reg [2:0] ifetch_target,
  output reg ifetch_cacheable,
  output reg ifetch_unmapped,
  output reg ifetch_valid,
  // Data requester
  input wire data_req,
  input wire [31:0] data_vaddr,
  input wire data_kernel_mode,
  output reg [31:0] data_paddr,
  output reg [2:0] data_target,
  output reg data_cacheable,
  output reg data_unmapped,
  output reg data_valid,
  // Fetch start address after reset
  output wire [31:0] reset_fetch_addr
);
  // ------------------------------------------------
  // Partition base registers
  // ------------------------------------------------
  reg [31:0] user_flash_base;
  reg [31:0] kernel_ram_program_base;
  reg [31:0] user_ram_data_base;
  reg [31:0] user_ram_program_base;
  reg [1:0] unmapped_seen;

  assign reset_fetch_addr = `MPD_RESET_VECTOR;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_flash_base <= 32'h0;
      kernel_ram_program_base <= 32'h0;
      user_ram_data_base <= 32'h0;
      user_ram_program_base <= 32'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `MPD_REG_USER_FLASH_BASE: user_flash_base <= reg_wdata & `MPD_FLASH_BASE_MASK;
        `MPD_REG_KRAM_PROG_BASE: kernel_ram_program_base <= reg_wdata & `MPD_RAM_BASE_MASK;
        `MPD_REG_USER_RAM_DATA_BASE: user_ram_data_base <= reg_wdata & `MPD_RAM_BASE_MASK;
        `MPD_REG_USER_RAM_PROG_BASE: user_ram_program_base <= reg_wdata & `MPD_RAM_BASE_MASK;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------
  // Register reads
  // ------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `MPD_REG_USER_FLASH_BASE: reg_rdata <= user_flash_base;
        `MPD_REG_KRAM_PROG_BASE: reg_rdata <= kernel_ram_program_base;
        `MPD_REG_USER_RAM_DATA_BASE: reg_rdata <= user_ram_data_base;
        `MPD_REG_USER_RAM_PROG_BASE: reg_rdata <= user_ram_program_base;
        `MPD_REG_DATA_RAM_SIZE: reg_rdata <= `MPD_DATA_RAM_SIZE;
        `MPD_REG_PROGRAM_FLASH_SIZE: reg_rdata <= `MPD_PROGRAM_FLASH_SIZE;
        `MPD_REG_BOOT_FLASH_SIZE: reg_rdata <= `MPD_BOOT_FLASH_SIZE;
        `MPD_REG_STATUS: reg_rdata <= {30'h0, unmapped_seen};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ------------------------------------------------
  // Decoders
  // ------------------------------------------------
  wire [31:0] i_paddr;
  wire [2:0] i_target;
  wire i_cache;
  wire i_unmapped;
  wire [31:0] d_paddr;
  wire [2:0] d_target;
  wire d_cache;
  wire d_unmapped;

  mpd_decode u_ifetch (
    .vaddr(ifetch_vaddr),
    .kernel_mode(ifetch_kernel_mode),
    .is_fetch(1'b1),
    .user_flash_base(user_flash_base),
    .kernel_ram_program_base(kernel_ram_program_base),
    .user_ram_data_base(user_ram_data_base),
    .user_ram_program_base(user_ram_program_base),
    .paddr(i_paddr),
    .target(i_target),
    .cacheable(i_cache),
    .unmapped(i_unmapped)
  );

  mpd_decode u_data (
    .vaddr(data_vaddr),
    .kernel_mode(data_kernel_mode),
    .is_fetch(1'b0),
    .user_flash_base(user_flash_base),
    .kernel_ram_program_base(kernel_ram_program_base),
    .user_ram_data_base(user_ram_data_base),
    .user_ram_program_base(user_ram_program_base),
    .paddr(d_paddr),
    .target(d_target),
    .cacheable(d_cache),
    .unmapped(d_unmapped)
  );

  // ------------------------------------------------
  // Registered results
  // ------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ifetch_paddr <= 32'h0;
      ifetch_target <= `MPD_TGT_NONE;
      ifetch_cacheable <= 1'b0;
      ifetch_unmapped <= 1'b0;
      ifetch_valid <= 1'b0;
      data_paddr <= 32'h0;
      data_target <= `MPD_TGT_NONE;
      data_cacheable <= 1'b0;
      data_unmapped <= 1'b0;
      data_valid <= 1'b0;
    end else begin
      ifetch_valid <= ifetch_req;
      data_valid <= data_req;
      if (ifetch_req) begin
        ifetch_paddr <= i_paddr;
        ifetch_target <= i_target;
        ifetch_cacheable <= i_cache;
        ifetch_unmapped <= i_unmapped;
      end
      if (data_req) begin
        data_paddr <= d_paddr;
        data_target <= d_target;
        data_cacheable <= d_cache;
        data_unmapped <= d_unmapped;
      end
    end
  end

  // Sticky unmapped flags; a new event wins over a clearing write
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unmapped_seen <= 2'h0;
    end else begin
      unmapped_seen <= ((reg_wr && reg_addr == `MPD_REG_STATUS) ?
                        (unmapped_seen & ~reg_wdata[1:0]) : unmapped_seen) |
                       {data_req & d_unmapped, ifetch_req & i_unmapped};
    end
  end
endmodule // mpd_top

/* File: bench/mpd_checker.sv */
// Purpose: port assertions for the partition decoder
// Assumes: registered decode, read data one cycle after the strobe
// Notes: bound into every decoder top instance
`timescale 1ns/1ps
module mpd_checker (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Requesters and results
  input wire ifetch_req,
  input wire [31:0] ifetch_vaddr,
  input wire ifetch_kernel_mode,
  input wire [2:0] ifetch_target,
  input wire ifetch_unmapped,
  input wire ifetch_valid,
  input wire data_req,
  input wire [31:0] data_vaddr,
  input wire [31:0] data_paddr,
  input wire data_cacheable,
  input wire data_unmapped,
  input wire data_valid,
  input wire [31:0] reset_fetch_addr
);
  wire i_user_k = ifetch_req && !ifetch_kernel_mode && ifetch_vaddr[31];
  wire d_kseg = data_req && data_vaddr[31:30] == 2'b10;
  wire d_useg = data_req && data_vaddr[31:28] == 4'h7;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  fetch_start_a: assert property (reset_fetch_addr == 32'hbfc00000)
    else $error("fetch start address wrong");
  boot_size_a: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h00003000)
    else $error("boot flash size wrong");
  base_step_a: assert property (reg_rd && reg_addr < 8'h10 |=> reg_rdata[10:0] == 11'h000)
    else $error("base low bits not zero");
  user_kseg_a: assert property (i_user_k |=> ifetch_valid && ifetch_unmapped)
    else $error("kernel segment reached in user mode");
  kseg_phys_a: assert property (d_kseg |=> data_unmapped ||
    data_paddr == ($past(data_vaddr) & 32'h1fffffff)) else $error("kernel segment paddr wrong");
  useg_phys_a: assert property (d_useg |=> data_unmapped ||
    data_paddr == $past(data_vaddr) + 32'h40000000) else $error("user segment paddr wrong");
  cache_seg_a: assert property (d_kseg |=> data_unmapped ||
    data_cacheable != $past(data_vaddr[29])) else $error("cacheable flag wrong");
  kseg_high_a: assert property (data_req && data_vaddr[31:30] == 2'b11 |=> data_unmapped)
    else $error("upper kernel segments mapped");
  unmap_tgt_a: assert property (ifetch_valid && ifetch_unmapped |-> ifetch_target == 3'h0)
    else $error("unmapped fetch has a target");
  cover property (ifetch_valid && !ifetch_unmapped);
  cover property (data_valid && data_cacheable);
  cover property (data_valid && data_unmapped);
endmodule // mpd_checker

bind mpd_top mpd_checker u_chk (.sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .ifetch_req,
  .ifetch_vaddr, .ifetch_kernel_mode, .ifetch_target, .ifetch_unmapped, .ifetch_valid,
  .data_req, .data_vaddr, .data_paddr, .data_cacheable, .data_unmapped, .data_valid,
  .reset_fetch_addr);

/* File: bench/mpd_cpu_model.sv */
// Purpose: one CPU requester in front of the decoder
// Assumes: a request is taken on the edge after it is raised
// Notes: address is scrambled once released
`timescale 1ns/1ps
module mpd_cpu_model (
  // Clock
  input wire sys_clk,
  // Request
  output reg req,
  output reg [31:0] vaddr,
  output reg kernel_mode
);
  initial begin
    req = 1'b0;
    vaddr = 32'h0;
    kernel_mode = 1'b1;
  end
  task issue(input [31:0] va, input km);
    begin
      @(posedge sys_clk);
      req <= 1'b1;
      vaddr <= va;
      kernel_mode <= km;
      @(posedge sys_clk);
      req <= 1'b0;
      vaddr <= ~va;
      kernel_mode <= ~km;
    end
  endtask
endmodule // mpd_cpu_model

/* File: bench/memory_partition_decoder_tb.sv */
// Purpose: self-checking bench for the partition decoder
// Assumes: 10 MHz clock, reset held three cycles
// Notes: flash and RAM partitions are moved through the register port
`timescale 1ns/1ps
module memory_partition_decoder_tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [31:0] reg_rdata, ifetch_vaddr, ifetch_paddr, data_vaddr, data_paddr, reset_fetch_addr;
  wire [2:0] ifetch_target, data_target;
  wire ifetch_req, ifetch_kernel_mode, ifetch_cacheable, ifetch_unmapped, ifetch_valid;
  wire data_req, data_kernel_mode, data_cacheable, data_unmapped, data_valid;
  integer n_errors = 0;
  integer n_compared = 0;
  integer cycles = 0;
  always #50 sys_clk = ~sys_clk;
  mpd_top u_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ifetch_req, .ifetch_vaddr, .ifetch_kernel_mode, .ifetch_paddr, .ifetch_target,
    .ifetch_cacheable, .ifetch_unmapped, .ifetch_valid, .data_req, .data_vaddr,
    .data_kernel_mode, .data_paddr, .data_target, .data_cacheable, .data_unmapped,
    .data_valid, .reset_fetch_addr);
  mpd_cpu_model u_ifetch (.sys_clk, .req(ifetch_req), .vaddr(ifetch_vaddr),
    .kernel_mode(ifetch_kernel_mode));
  mpd_cpu_model u_data (.sys_clk, .req(data_req), .vaddr(data_vaddr),
    .kernel_mode(data_kernel_mode));
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string what, input [36:0] seen, input [36:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {5'h0, reg_rdata}, {5'h0, e});
    end
  endtask
  // Unmapped results carry no meaningful physical address
  task dec(input f, input [31:0] va, input km, input [31:0] pa, input [2:0] tg, input um);
    reg [36:0] seen;
    begin
      if (f) u_ifetch.issue(va, km);
      else u_data.issue(va, km);
      #1;
      seen = f ? {ifetch_valid, ifetch_paddr, ifetch_target, ifetch_unmapped}
        : {data_valid, data_paddr, data_target, data_unmapped};
      if (um) seen[35:4] = 32'h0;
      chk("decode", seen, {1'b1, pa, tg, um});
    end
  endtask
  task t_regs;
    begin
      chk("reset_fetch_addr", {5'h0, reset_fetch_addr}, {5'h0, 32'hbfc00000});
      rd(8'h18, 32'h00003000);
      wr(8'h18, 32'hffffffff);
      rd(8'h18, 32'h00003000);
      rd(8'h00, 32'h0);
      wr(8'h00, 32'hffffffff);
      rd(8'h00, 32'h000ff800);
      rd(8'h20, 32'h0);
      wr(8'h00, 32'h0);
      rd(8'h10, 32'h00008000);
      rd(8'h14, 32'h00080000);
      wr(8'h04, 32'hffffffff);
      rd(8'h04, 32'h0000f800);
      wr(8'h04, 32'h0);
      $display("test registers done");
    end
  endtask
  task t_flash;
    begin
      dec(1, 32'hbfc00000, 1, 32'h1fc00000, 3'h3, 0);
      chk("ifetch_cacheable", {36'h0, ifetch_cacheable}, 37'h0);
      dec(1, 32'h9fc00010, 1, 32'h1fc00010, 3'h3, 0);
      chk("ifetch_cacheable", {36'h0, ifetch_cacheable}, 37'h1);
      dec(0, 32'hbd000010, 1, 32'h1d000010, 3'h2, 0);
      chk("data_cacheable", {36'h0, data_cacheable}, 37'h0);
      dec(0, 32'h9d000010, 1, 32'h1d000010, 3'h2, 0);
      chk("data_cacheable", {36'h0, data_cacheable}, 37'h1);
      dec(0, 32'h7d000010, 1, 32'h0, 3'h0, 1);
      dec(1, 32'hbd000010, 0, 32'h0, 3'h0, 1);
      wr(8'h00, 32'h00080000 - 32'h00005000);
      dec(0, 32'h7d07b010, 0, 32'hbd07b010, 3'h2, 0);
      dec(1, 32'h7d07b010, 1, 32'hbd07b010, 3'h2, 0);
      dec(0, 32'hbd07b010, 1, 32'h0, 3'h0, 1);
      dec(0, 32'hbd07aff0, 1, 32'h1d07aff0, 3'h2, 0);
      $display("test flash done");
    end
  endtask
  task t_ram;
    begin
      dec(0, 32'h80000010, 1, 32'h00000010, 3'h1, 0);
      dec(1, 32'h80000010, 1, 32'h0, 3'h0, 1);
      wr(8'h04, 32'h00000800);
      wr(8'h08, 32'h00004000);
      wr(8'h0c, 32'h00006000);
      dec(1, 32'h80000810, 1, 32'h00000810, 3'h1, 0);
      dec(0, 32'h7f004010, 0, 32'hbf004010, 3'h1, 0);
      dec(1, 32'h7f004010, 0, 32'h0, 3'h0, 1);
      dec(1, 32'h7f006010, 0, 32'hbf006010, 3'h1, 0);
      dec(0, 32'ha0004010, 1, 32'h0, 3'h0, 1);
      dec(0, 32'ha0003ff0, 1, 32'h00003ff0, 3'h1, 0);
      $display("test ram done");
    end
  endtask
  task t_gaps;
    begin
      dec(0, 32'h20000000, 1, 32'h0, 3'h0, 1);
      dec(0, 32'hc0000000, 1, 32'h0, 3'h0, 1);
      dec(0, 32'hbf900000, 1, 32'h0, 3'h0, 1);
      dec(0, 32'hbf800010, 0, 32'h0, 3'h0, 1);
      dec(0, 32'hbf800010, 1, 32'h1f800010, 3'h4, 0);
      rd(8'h1c, 32'h00000003);
      wr(8'h1c, 32'h00000001);
      rd(8'h1c, 32'h00000002);
      $display("test gaps done");
    end
  endtask
  task t_reset;
    begin
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h1c, 32'h0);
      dec(0, 32'h7d07b010, 0, 32'h0, 3'h0, 1);
      wr(8'h0c, 32'h00006000);
      dec(0, 32'ha0000010, 1, 32'h00000010, 3'h1, 0);
      dec(0, 32'ha0006010, 1, 32'h0, 3'h0, 1);
      dec(0, 32'h7f006010, 0, 32'hbf006010, 3'h1, 0);
      $display("test reset done");
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_flash;
    t_ram;
    t_gaps;
    t_reset;
    conclude;
  end
endmodule // memory_partition_decoder_tb
